/* File: hw/ivv_cmd_exec.sv */
/*
  Command executor for accumulator rotate, indexed user-variable and user-function opcodes.
  Takes 9-byte frames one byte per strobe, checks the checksum, executes, and raises a reply.
  Assumes the surrounding interpreter owns motion ramping and the transport.
*/
// Functional notes
// - Opcode 50 starts rotation decreasing position; type and bank ignored.
// - Opcode 51 starts rotation increasing position; type and bank ignored.
// - Rotate by accumulator selects velocity mode and loads accumulator as target velocity on the same edge.
// - Opcode 55 writes frame value into user variable indexed by X.
// - Indexed commands do nothing when X is below 0 or above 255.
// - Opcode 38 loads accumulator from user variable indexed by X.
// - Opcode 39 stores accumulator into user variable indexed by X.
// - Opcodes 64..71 take customer fields and reply OK with user value.
// - Opcode 131 pulses app_reset_o to stop the program and clears accumulator and X.
`timescale 1ns/1ps
module ivv_cmd_exec #(
  parameter int VAR_DEPTH = 256
) (
  input  wire logic        ref_clk_i,
  input  wire logic        rst_i,
  input  wire logic        rx_valid_i,
  input  wire logic [7:0]  rx_byte_i,
  input  wire logic        acc_load_i,
  input  wire logic [31:0] acc_load_val_i,
  input  wire logic        x_load_i,
  input  wire logic [31:0] x_load_val_i,
  input  wire logic [31:0] user_fn_value_i,
  output logic      [31:0] acc_o,
  output logic      [31:0] x_reg_o,
  output logic             velocity_mode_o,
  output logic             target_vel_we_o,
  output logic      [31:0] target_velocity_o,
  output logic             rot_dir_o,
  output logic             app_reset_o,
  output logic             user_fn_o,
  output logic      [2:0]  user_fn_num_o,
  output logic      [7:0]  user_fn_type_o,
  output logic      [7:0]  user_fn_bank_o,
  output logic      [31:0] user_fn_val_o,
  output logic             reply_valid_o,
  output logic      [7:0]  reply_status_o,
  output logic      [7:0]  reply_cmd_o,
  output logic      [31:0] reply_value_o
);
  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_RECV  = 2'b00,
    ST_EXEC  = 2'b01,
    ST_FETCH = 2'b10,
    ST_REPLY = 2'b11
  } ivv_state_type;

  ivv_state_type state_reg;
  logic [3:0]    cnt_reg;
  logic [7:0]    sum_reg;
  logic [7:0]    op_reg;
  logic [7:0]    type_reg;
  logic [7:0]    bank_reg;
  logic [31:0]   val_reg;
  logic [7:0]    csum_reg;
  logic [31:0]   acc_reg;
  logic [31:0]   x_reg;
  logic          var_we;
  logic [31:0]   var_wdata;
  logic [31:0]   var_rdata;
  logic          idx_ok;
  logic          is_user_fn;
  logic          csum_ok;

  assign idx_ok     = (x_reg <= ivv_pkg::IDX_MAX);
  assign is_user_fn = (op_reg >= ivv_pkg::OP_USER_FN_BASE) && (op_reg <= ivv_pkg::OP_USER_FN_LAST);
  assign csum_ok    = (sum_reg == csum_reg);

  // ---------------------------------------------------------------
  // Frame capture
  // ---------------------------------------------------------------
  // Bytes arriving outside ST_RECV are dropped; the host waits for the reply.
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      cnt_reg  <= ivv_pkg::CNT_ZERO;
      sum_reg  <= 8'h00;
      op_reg   <= 8'h00;
      type_reg <= 8'h00;
      bank_reg <= 8'h00;
      val_reg  <= ivv_pkg::ZERO_WORD;
      csum_reg <= 8'h00;
    end else if (state_reg == ST_RECV && rx_valid_i) begin
      // Fixed field order, value most significant byte first
      case (cnt_reg)
        ivv_pkg::IDX_OPCODE: op_reg   <= rx_byte_i;
        ivv_pkg::IDX_TYPE:   type_reg <= rx_byte_i;
        ivv_pkg::IDX_BANK:   bank_reg <= rx_byte_i;
        ivv_pkg::CNT_LAST:   csum_reg <= rx_byte_i;
        default: begin
          if (cnt_reg >= ivv_pkg::IDX_VAL_MSB && cnt_reg <= ivv_pkg::IDX_VAL_LSB) begin
            val_reg <= {val_reg[23:0], rx_byte_i};
          end
        end
      endcase
      if (cnt_reg == ivv_pkg::CNT_LAST) begin
        cnt_reg <= ivv_pkg::CNT_ZERO;
      end else begin
        cnt_reg <= cnt_reg + 4'h1;
        sum_reg <= (cnt_reg == ivv_pkg::CNT_ZERO) ? rx_byte_i : sum_reg + rx_byte_i;
      end
    end
  end

  // ---------------------------------------------------------------
  // Sequencer
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_reg <= ST_RECV;
    end else begin
      case (state_reg)
        ST_RECV:  if (rx_valid_i && cnt_reg == ivv_pkg::CNT_LAST) state_reg <= ST_EXEC;
        ST_EXEC:  state_reg <= (csum_ok && op_reg == ivv_pkg::OP_GET_IDX_VAR && idx_ok) ? ST_FETCH : ST_REPLY;
        ST_FETCH: state_reg <= ST_REPLY;
        ST_REPLY: state_reg <= ST_RECV;
        default:  state_reg <= ST_RECV;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Accumulator and X register
  // ---------------------------------------------------------------
  // Command results take priority over the interpreter's own loads.
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      acc_reg <= ivv_pkg::ZERO_WORD;
      x_reg   <= ivv_pkg::ZERO_WORD;
    end else if (state_reg == ST_EXEC && csum_ok && op_reg == ivv_pkg::OP_APP_RESET) begin
      acc_reg <= ivv_pkg::ZERO_WORD;
      x_reg   <= ivv_pkg::ZERO_WORD;
    end else begin
      if (state_reg == ST_FETCH) begin
        acc_reg <= var_rdata;
      end else if (acc_load_i) begin
        acc_reg <= acc_load_val_i;
      end
      if (x_load_i) begin
        x_reg <= x_load_val_i;
      end
    end
  end

  // ---------------------------------------------------------------
  // User-variable store access
  // ---------------------------------------------------------------
  always_comb begin
    var_we    = 1'b0;
    var_wdata = val_reg;
    if (state_reg == ST_EXEC && csum_ok && idx_ok) begin
      if (op_reg == ivv_pkg::OP_SET_IDX_VAR) begin
        var_we    = 1'b1;
      end else if (op_reg == ivv_pkg::OP_ACC_IDX_VAR) begin
        var_we    = 1'b1;
        var_wdata = acc_reg;
      end
    end
  end

  ivv_var_store #(
    .DEPTH (VAR_DEPTH),
    .AW    (8)
  ) u_store (
    .ref_clk_i (ref_clk_i),
    .we_i      (var_we),
    .addr_i    (x_reg[7:0]),
    .wdata_i   (var_wdata),
    .rdata_o   (var_rdata)
  );

  // ---------------------------------------------------------------
  // Motion and control outputs
  // ---------------------------------------------------------------
  logic rot_cmd;
  assign rot_cmd = state_reg == ST_EXEC && csum_ok &&
                   (op_reg == ivv_pkg::OP_ROT_LEFT_ACC || op_reg == ivv_pkg::OP_ROT_RIGHT_ACC);
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      velocity_mode_o   <= 1'b0;
      target_vel_we_o   <= 1'b0;
      target_velocity_o <= ivv_pkg::ZERO_WORD;
      rot_dir_o         <= ivv_pkg::DIR_RIGHT;
      app_reset_o       <= 1'b0;
    end else begin
      target_vel_we_o <= 1'b0;
      app_reset_o     <= 1'b0;
      if (rot_cmd) begin
        // Mode and velocity land in the same edge; mode is never behind velocity.
        velocity_mode_o   <= 1'b1;
        target_vel_we_o   <= 1'b1;
        target_velocity_o <= acc_reg;
        rot_dir_o         <= (op_reg == ivv_pkg::OP_ROT_LEFT_ACC) ? ivv_pkg::DIR_LEFT
                                                                   : ivv_pkg::DIR_RIGHT;
      end
      if (state_reg == ST_EXEC && csum_ok && op_reg == ivv_pkg::OP_APP_RESET) begin
        app_reset_o <= 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      user_fn_o      <= 1'b0;
      user_fn_num_o  <= 3'h0;
      user_fn_type_o <= 8'h00;
      user_fn_bank_o <= 8'h00;
      user_fn_val_o  <= ivv_pkg::ZERO_WORD;
    end else begin
      user_fn_o <= state_reg == ST_EXEC && csum_ok && is_user_fn;
      if (state_reg == ST_EXEC && csum_ok && is_user_fn) begin
        user_fn_num_o  <= op_reg[2:0];
        user_fn_type_o <= type_reg;
        user_fn_bank_o <= bank_reg;
        user_fn_val_o  <= val_reg;
      end
    end
  end

  // ---------------------------------------------------------------
  // Reply
  // ---------------------------------------------------------------
  logic known_op;
  assign known_op = is_user_fn || op_reg == ivv_pkg::OP_ROT_LEFT_ACC || op_reg == ivv_pkg::OP_ROT_RIGHT_ACC ||
                    op_reg == ivv_pkg::OP_SET_IDX_VAR || op_reg == ivv_pkg::OP_GET_IDX_VAR ||
                    op_reg == ivv_pkg::OP_ACC_IDX_VAR || op_reg == ivv_pkg::OP_APP_RESET;
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      reply_status_o <= 8'h00;
      reply_cmd_o    <= 8'h00;
      reply_value_o  <= ivv_pkg::ZERO_WORD;
    end else if (state_reg == ST_EXEC) begin
      reply_cmd_o    <= op_reg;
      reply_value_o  <= ivv_pkg::ZERO_WORD;
      if (!csum_ok) begin
        reply_status_o <= ivv_pkg::ST_BAD_CHECKSUM;
      end else if (!known_op) begin
        reply_status_o <= ivv_pkg::ST_BAD_OPCODE;
      end else begin
        reply_status_o <= ivv_pkg::ST_OK;
        if (is_user_fn) begin
          reply_value_o <= user_fn_value_i;
        end
      end
    end
  end
  assign reply_valid_o = (state_reg == ST_REPLY);
  assign acc_o         = acc_reg;
  assign x_reg_o       = x_reg;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  a_rot_left_dir: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    rot_cmd && op_reg == ivv_pkg::OP_ROT_LEFT_ACC |=> rot_dir_o == ivv_pkg::DIR_LEFT && target_vel_we_o)
    else $error("left rotate did not set left direction");
  a_rot_right_dir: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    rot_cmd && op_reg == ivv_pkg::OP_ROT_RIGHT_ACC |=> rot_dir_o == ivv_pkg::DIR_RIGHT)
    else $error("right rotate did not set right direction");
  a_vel_from_acc: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    target_vel_we_o |-> velocity_mode_o && target_velocity_o == $past(acc_reg))
    else $error("target velocity not from accumulator in velocity mode");
  a_set_var_write: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    var_we && op_reg == ivv_pkg::OP_SET_IDX_VAR |=> u_store.mem[$past(x_reg[7:0])] == $past(val_reg))
    else $error("set indexed variable wrote wrong data");
  a_idx_guard: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    var_we |-> x_reg <= ivv_pkg::IDX_MAX)
    else $error("store written with index out of range");
  a_get_var_load: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    state_reg == ST_FETCH && !(state_reg == ST_EXEC) |=> acc_reg == $past(var_rdata))
    else $error("get indexed variable did not load accumulator");
  a_acc_var_write: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    var_we && op_reg == ivv_pkg::OP_ACC_IDX_VAR |=> u_store.mem[$past(x_reg[7:0])] == $past(acc_reg))
    else $error("accumulator store wrote wrong data");
  a_user_fn_ok: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    user_fn_o |-> reply_valid_o && reply_status_o == ivv_pkg::ST_OK)
    else $error("user function reply not OK");
  a_bad_sum: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    state_reg == ST_EXEC && !csum_ok |=> reply_status_o == ivv_pkg::ST_BAD_CHECKSUM && !target_vel_we_o)
    else $error("bad checksum not refused");
  a_app_reset: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    app_reset_o |-> acc_reg == ivv_pkg::ZERO_WORD && x_reg == ivv_pkg::ZERO_WORD)
    else $error("application reset left state");
  c_rotate: cover property (@(posedge ref_clk_i) disable iff (rst_i) target_vel_we_o);
  c_fetch:  cover property (@(posedge ref_clk_i) disable iff (rst_i) state_reg == ST_FETCH);
  c_store:  cover property (@(posedge ref_clk_i) disable iff (rst_i) var_we);
  c_user:   cover property (@(posedge ref_clk_i) disable iff (rst_i) user_fn_o);
endmodule

/* File: hw/ivv_pkg.sv */
/*
  Shared constants for the indexed-variable / accumulator-velocity command executor.
  Assumes a byte-wide frame receiver and a single system clock.
*/
package ivv_pkg;
  // ---------------------------------------------------------------
  // Frame layout and opcodes
  // ---------------------------------------------------------------
  localparam int          FRAME_BYTES      = 9;
  localparam logic [7:0]  OP_ROT_RIGHT_ACC = 8'h33;
  localparam logic [7:0]  OP_ROT_LEFT_ACC  = 8'h32;
  localparam logic [7:0]  OP_SET_IDX_VAR   = 8'h37;
  localparam logic [7:0]  OP_GET_IDX_VAR   = 8'h26;
  localparam logic [7:0]  OP_ACC_IDX_VAR   = 8'h27;
  localparam logic [7:0]  OP_USER_FN_BASE  = 8'h40;
  localparam logic [7:0]  OP_USER_FN_LAST  = 8'h47;
  localparam logic [7:0]  OP_APP_RESET     = 8'h83;
  // ---------------------------------------------------------------
  // Reply status codes, host address, index limit, frame counters, directions
  // ---------------------------------------------------------------
  localparam logic [7:0]  ST_OK            = 8'h64;
  localparam logic [7:0]  ST_BAD_CHECKSUM  = 8'h01;
  localparam logic [7:0]  ST_BAD_OPCODE    = 8'h02;
  localparam logic [7:0]  HOST_ADDR        = 8'h02;
  localparam logic [31:0] IDX_MAX          = 32'h0000_00ff;
  localparam logic [31:0] ZERO_WORD        = 32'h0000_0000;
  localparam logic [3:0]  CNT_LAST         = 4'h8;
  localparam logic [3:0]  CNT_ZERO         = 4'h0;
  localparam logic [3:0]  IDX_OPCODE       = 4'h1;
  localparam logic [3:0]  IDX_TYPE         = 4'h2;
  localparam logic [3:0]  IDX_BANK         = 4'h3;
  localparam logic [3:0]  IDX_VAL_MSB      = 4'h4;
  localparam logic [3:0]  IDX_VAL_LSB      = 4'h7;
  localparam logic        DIR_LEFT         = 1'b0;
  localparam logic        DIR_RIGHT        = 1'b1;
endpackage

/* File: hw/ivv_var_store.sv */
/*
  User-variable store: 256 words, one write port, one registered read port.
  Assumes the executor qualifies the index range before it strobes.
*/
`timescale 1ns/1ps
module ivv_var_store #(
  parameter int DEPTH = 256,
  parameter int AW    = 8
) (
  input  wire logic          ref_clk_i,
  input  wire logic          we_i,
  input  wire logic [AW-1:0] addr_i,
  input  wire logic [31:0]   wdata_i,
  output logic      [31:0]   rdata_o
);
  // No reset on the array: keeps it mappable to RAM; contents undefined at power-up.
  logic [31:0] mem [DEPTH];

  always_ff @(posedge ref_clk_i) begin
    if (we_i) begin
      mem[addr_i] <= wdata_i;
    end
    rdata_o <= mem[addr_i];
  end
endmodule

/* File: tb/ivv_host_model.sv */
/*
  Host-side model: sends 9-byte command frames one byte per clock.
  Assumes the bench calls send() from one process and waits for the reply itself.
*/
`timescale 1ns/1ps
module ivv_host_model (
  input  wire logic       ref_clk_i,
  output logic            rx_valid_o,
  output logic      [7:0] rx_byte_o
);
  // ---------------------------------------------------------------
  // Frame sender
  // ---------------------------------------------------------------
  initial begin
    rx_valid_o = 1'b0;
    rx_byte_o  = 8'h00;
  end

  // Bad flag inverts the checksum so the receiver must refuse the frame
  task automatic send(input logic [7:0] op, input logic [7:0] typ, input logic [7:0] bank,
                      input logic [31:0] val, input logic bad);
    logic [7:0] fr [9];
    logic [7:0] sum;
    fr[0] = 8'h01;
    fr[1] = op;
    fr[2] = typ;
    fr[3] = bank;
    for (int i = 0; i < 4; i++) fr[4+i] = val[31-8*i -: 8];
    sum = 8'h00;
    for (int i = 0; i < 8; i++) sum = sum + fr[i];
    fr[8] = bad ? ~sum : sum;
    for (int i = 0; i < 9; i++) begin
      @(negedge ref_clk_i);
      rx_valid_o = 1'b1;
      rx_byte_o  = fr[i];
    end
    @(negedge ref_clk_i);
    rx_valid_o = 1'b0;
    // Idle line shows no stale byte
    rx_byte_o  = ~fr[8];
  endtask
endmodule

/* File: tb/ivv_cmd_exec_tb.sv */
/*
  Self-checking bench for the command executor.
  Assumes the host model drives frames and the bench drives the interpreter-side loads.
*/
`timescale 1ns/1ps
module ivv_cmd_exec_tb;
  logic        ref_clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        rx_valid_i;
  logic [7:0]  rx_byte_i;
  logic        acc_load_i = 1'b0;
  logic [31:0] acc_load_val_i = 32'h0000_0000;
  logic        x_load_i = 1'b0;
  logic [31:0] x_load_val_i = 32'h0000_0000;
  logic [31:0] user_fn_value_i = 32'h0000_0000;
  logic [31:0] acc_o, x_reg_o, target_velocity_o, user_fn_val_o, reply_value_o, vl;
  logic        velocity_mode_o, target_vel_we_o, rot_dir_o, app_reset_o, user_fn_o, reply_valid_o, we, ar, uf;
  logic [2:0]  user_fn_num_o;
  logic [7:0]  user_fn_type_o, user_fn_bank_o, reply_status_o, reply_cmd_o, st;
  int          num_errors = 0;
  int          compares = 0;

  always #5 ref_clk_i = ~ref_clk_i;

  ivv_host_model ivv_host_model_inst (.ref_clk_i(ref_clk_i), .rx_valid_o(rx_valid_i), .rx_byte_o(rx_byte_i));

  ivv_cmd_exec ivv_cmd_exec_inst (
    .ref_clk_i(ref_clk_i), .rst_i(rst_i), .rx_valid_i(rx_valid_i), .rx_byte_i(rx_byte_i),
    .acc_load_i(acc_load_i), .acc_load_val_i(acc_load_val_i), .x_load_i(x_load_i),
    .x_load_val_i(x_load_val_i), .user_fn_value_i(user_fn_value_i), .acc_o(acc_o), .x_reg_o(x_reg_o),
    .velocity_mode_o(velocity_mode_o), .target_vel_we_o(target_vel_we_o),
    .target_velocity_o(target_velocity_o), .rot_dir_o(rot_dir_o), .app_reset_o(app_reset_o),
    .user_fn_o(user_fn_o), .user_fn_num_o(user_fn_num_o), .user_fn_type_o(user_fn_type_o),
    .user_fn_bank_o(user_fn_bank_o), .user_fn_val_o(user_fn_val_o), .reply_valid_o(reply_valid_o),
    .reply_status_o(reply_status_o), .reply_cmd_o(reply_cmd_o), .reply_value_o(reply_value_o));

  // ---------------------------------------------------------------
  // Access tasks
  // ---------------------------------------------------------------
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      $display("ERROR %s expected %h seen %h", what, exp, got);
      num_errors++;
    end
  endtask

  // Reply is a one-cycle pulse, so it is captured in the cycle it stands
  task automatic cmd(input logic [7:0] op, input logic [7:0] typ, input logic [7:0] bank,
                     input logic [31:0] val, input logic bad);
    int n;
    n = 0;
    ivv_host_model_inst.send(op, typ, bank, val, bad);
    while (reply_valid_o !== 1'b1 && n < 8) begin
      @(negedge ref_clk_i);
      n++;
    end
    chk("reply seen", 32'h1, {31'h0, reply_valid_o});
    st = reply_status_o;
    vl = reply_value_o;
    we = target_vel_we_o;
    ar = app_reset_o;
    uf = user_fn_o;
    chk("reply cmd", {24'h0, op}, {24'h0, reply_cmd_o});
    @(negedge ref_clk_i);
  endtask

  task automatic ld(input logic acc, input logic [31:0] v);
    @(negedge ref_clk_i);
    if (acc) begin
      acc_load_i = 1'b1;
      acc_load_val_i = v;
    end else begin
      x_load_i = 1'b1;
      x_load_val_i = v;
    end
    @(negedge ref_clk_i);
    acc_load_i = 1'b0;
    x_load_i = 1'b0;
  endtask

  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // ---------------------------------------------------------------
  // Tests
  // ---------------------------------------------------------------
  initial begin
    #100000;
    num_errors++;
    give_verdict();
  end

  initial begin
    repeat (2) @(negedge ref_clk_i);
    rst_i = 1'b0;
    chk("dir reset", 32'h1, {31'h0, rot_dir_o});
    chk("acc reset", 32'h0, acc_o);
    $display("test reset done");
    // Nonzero type and bank must not matter
    ld(1'b1, 32'h0001_2345);
    cmd(ivv_pkg::OP_ROT_LEFT_ACC, 8'h5a, 8'h3c, 32'h0, 1'b0);
    chk("left dir", {31'h0, ivv_pkg::DIR_LEFT}, {31'h0, rot_dir_o});
    chk("vel mode", 32'h1, {31'h0, velocity_mode_o});
    chk("vel we", 32'h1, {31'h0, we});
    chk("target vel", 32'h0001_2345, target_velocity_o);
    chk("rot status", {24'h0, ivv_pkg::ST_OK}, {24'h0, st});
    ld(1'b1, 32'hffff_fff0);
    cmd(ivv_pkg::OP_ROT_RIGHT_ACC, 8'hff, 8'h07, 32'h0, 1'b0);
    chk("right dir", {31'h0, ivv_pkg::DIR_RIGHT}, {31'h0, rot_dir_o});
    chk("target vel", 32'hffff_fff0, target_velocity_o);
    ld(1'b1, 32'h0000_0777);
    cmd(ivv_pkg::OP_ROT_LEFT_ACC, 8'h00, 8'h00, 32'h0, 1'b1);
    chk("bad sum status", {24'h0, ivv_pkg::ST_BAD_CHECKSUM}, {24'h0, st});
    chk("dir kept", {31'h0, ivv_pkg::DIR_RIGHT}, {31'h0, rot_dir_o});
    chk("vel kept", 32'hffff_fff0, target_velocity_o);
    cmd(8'h10, 8'h00, 8'h00, 32'h0, 1'b0);
    chk("bad op status", {24'h0, ivv_pkg::ST_BAD_OPCODE}, {24'h0, st});
    $display("test rotate done");
    ld(1'b0, 32'h0000_0005);
    cmd(ivv_pkg::OP_SET_IDX_VAR, 8'h00, 8'h00, 32'h1234_5678, 1'b0);
    ld(1'b1, 32'h0);
    cmd(ivv_pkg::OP_GET_IDX_VAR, 8'h00, 8'h00, 32'h0, 1'b0);
    chk("get var acc", 32'h1234_5678, acc_o);
    ld(1'b1, 32'hcafe_0001);
    ld(1'b0, 32'h0000_00ff);
    cmd(ivv_pkg::OP_ACC_IDX_VAR, 8'h00, 8'h00, 32'h0, 1'b0);
    ld(1'b1, 32'h0);
    cmd(ivv_pkg::OP_GET_IDX_VAR, 8'h00, 8'h00, 32'h0, 1'b0);
    chk("acc var top index", 32'hcafe_0001, acc_o);
    ld(1'b0, 32'h0);
    cmd(ivv_pkg::OP_SET_IDX_VAR, 8'h00, 8'h00, 32'h0000_0011, 1'b0);
    // Out-of-range indexes would alias 0 and 255 if truncated
    ld(1'b0, 32'h0000_0100);
    cmd(ivv_pkg::OP_SET_IDX_VAR, 8'h00, 8'h00, 32'h0000_0022, 1'b0);
    chk("skip status", {24'h0, ivv_pkg::ST_OK}, {24'h0, st});
    ld(1'b0, 32'hffff_ffff);
    ld(1'b1, 32'h0000_0077);
    cmd(ivv_pkg::OP_GET_IDX_VAR, 8'h00, 8'h00, 32'h0, 1'b0);
    chk("get var skipped", 32'h0000_0077, acc_o);
    cmd(ivv_pkg::OP_ACC_IDX_VAR, 8'h00, 8'h00, 32'h0, 1'b0);
    ld(1'b0, 32'h0);
    cmd(ivv_pkg::OP_GET_IDX_VAR, 8'h00, 8'h00, 32'h0, 1'b0);
    chk("var0 kept", 32'h0000_0011, acc_o);
    ld(1'b0, 32'h0000_00ff);
    cmd(ivv_pkg::OP_GET_IDX_VAR, 8'h00, 8'h00, 32'h0, 1'b0);
    chk("var255 kept", 32'hcafe_0001, acc_o);
    $display("test indexed done");
    for (int k = 0; k < 8; k++) begin
      user_fn_value_i = 32'h5500_0000 + k;
      cmd(ivv_pkg::OP_USER_FN_BASE + 8'(k), 8'h10 + 8'(k), 8'h20, 32'hab00_0000 + k, 1'b0);
      chk("fn status", {24'h0, ivv_pkg::ST_OK}, {24'h0, st});
      chk("fn pulse", 32'h1, {31'h0, uf});
      chk("fn value", 32'h5500_0000 + k, vl);
      chk("fn num", 32'(k), {29'h0, user_fn_num_o});
      chk("fn type", 32'h10 + k, {24'h0, user_fn_type_o});
      chk("fn bank", 32'h20, {24'h0, user_fn_bank_o});
      chk("fn val", 32'hab00_0000 + k, user_fn_val_o);
    end
    $display("test user functions done");
    ld(1'b0, 32'h0000_0042);
    ld(1'b1, 32'h0000_0099);
    cmd(ivv_pkg::OP_APP_RESET, 8'h00, 8'h00, 32'h0, 1'b0);
    chk("reset acc", 32'h0, acc_o);
    chk("reset x", 32'h0, x_reg_o);
    chk("reset status", {24'h0, ivv_pkg::ST_OK}, {24'h0, st});
    chk("reset pulse", 32'h1, {31'h0, ar});
    $display("test app reset done");
    give_verdict();
  end
endmodule
